// file: hw/rfid_cfg_params.svh
`ifndef RFID_CFG_PARAMS_SVH
`define RFID_CFG_PARAMS_SVH

// ****************************************************************************
// Register map
// ****************************************************************************
`define CFG_ADDR_W        5
`define CFG_ADDR_CTRL     5'h00
`define CFG_ADDR_PROTO    5'h01
`define CFG_CTRL_RESET    8'h01
`define CFG_PROTO_RESET   8'h02
`define CFG_UNMAPPED_READ 8'h00

// ****************************************************************************
// Low-level option register span reloaded on a protocol write
// ****************************************************************************
`define CFG_OPT_FIRST     5'h02
`define CFG_OPT_LAST      5'h0B

// ****************************************************************************
// Protocol code groups
// ****************************************************************************
`define CFG_CODE_RATE2_A  5'h1A
`define CFG_CODE_RATE2_B  5'h1B
`define CFG_GROUP_VICIN   2'h0
`define CFG_GROUP_PROX    2'h1
`define CFG_LOW_NONE      2'h0
`define CFG_LOW_106       2'h1
`define CFG_LOW_EMU_A     2'h0
`define CFG_LOW_EMU_B     2'h1

`endif

// file: hw/rfid_cfg_pkg.sv
package rfid_cfg_pkg;

  // ****************************************************************************
  // Register layouts, most significant bit first
  // ****************************************************************************
  typedef struct packed {
    logic low_power_hold;
    logic framing_bypass_select;
    logic rf_output_active;
    logic transmit_power_half;
    logic receive_input_choice;
    logic auto_gain_enable;
    logic forced_receiver_enable;
    logic supply_range_select;
  } power_ctrl_t;

  typedef struct packed {
    logic       receive_check_absent;
    logic       bypass_variant_select;
    logic       reader_vs_peer_select;
    logic       protocol_code_top;
    logic       protocol_code_bit3;
    logic       protocol_code_bit2;
    logic [1:0] protocol_code_low;
  } protocol_reg_t;

  // ****************************************************************************
  // Decoded operating mode
  // ****************************************************************************
  typedef enum logic [2:0] {
    FAM_VICINITY,
    FAM_PROX_A,
    FAM_PROX_B,
    FAM_RATE2,
    FAM_NFC_NORMAL,
    FAM_CARD_EMU_A,
    FAM_CARD_EMU_B,
    FAM_RESERVED
  } protocol_family_t;

  typedef struct packed {
    protocol_family_t family;
    logic             nfc_initiator;
    logic             nfc_active;
    logic [1:0]       rate_sel;
    logic             code_valid;
  } protocol_info_t;

  typedef enum logic {
    RELOAD_IDLE,
    RELOAD_RUN
  } reload_state_t;

endpackage : rfid_cfg_pkg

// file: hw/protocol_decode.sv
`timescale 1ns/10ps
`include "rfid_cfg_params.svh"

module protocol_decode
  import rfid_cfg_pkg::*;
(
  input  wire protocol_reg_t  proto,
  output protocol_info_t      info
);

  logic [4:0] code;

  assign code = {proto.protocol_code_top, proto.protocol_code_bit3, proto.protocol_code_bit2,
                 proto.protocol_code_low};

  always_comb begin
    info               = '0;
    info.family        = FAM_RESERVED;
    info.rate_sel      = proto.protocol_code_low;
    info.nfc_initiator = 1'b0;
    info.nfc_active    = 1'b0;
    info.code_valid    = 1'b0;
    if (!proto.reader_vs_peer_select) begin  // see R13
      // Five-bit reader protocol code.
      info.code_valid = 1'b1;  // see R14
      if (code[4:3] == `CFG_GROUP_VICIN) begin  // see R18
        info.family = FAM_VICINITY;
      end else if (code[4:3] == `CFG_GROUP_PROX) begin
        info.family = code[2] ? FAM_PROX_B : FAM_PROX_A;
      end else if (code == `CFG_CODE_RATE2_A || code == `CFG_CODE_RATE2_B) begin
        info.family = FAM_RATE2;
      end else begin
        info.code_valid = 1'b0;
      end
    end else begin
      info.nfc_initiator = proto.protocol_code_top;   // see R14
      info.nfc_active    = proto.protocol_code_bit3;  // see R15
      if (!proto.protocol_code_bit2) begin  // see R16
        // Bit rate 106, 212 or 424; the zero code has no meaning.
        info.family     = FAM_NFC_NORMAL;
        info.code_valid = (proto.protocol_code_low != `CFG_LOW_NONE);  // see R17
      end else if (proto.protocol_code_low == `CFG_LOW_EMU_A) begin
        info.family     = FAM_CARD_EMU_A;  // see R17
        info.code_valid = 1'b1;
      end else if (proto.protocol_code_low == `CFG_LOW_EMU_B) begin
        info.family     = FAM_CARD_EMU_B;
        info.code_valid = 1'b1;
      end else begin
        info.family     = FAM_RESERVED;
      end
    end
  end

endmodule : protocol_decode

// file: hw/rfid_nfc_main_config_regs.sv
`timescale 1ns/10ps
`include "rfid_cfg_params.svh"

// Summary of operation
// R01 - Standby bit holds regulators and oscillator running.
// R02 - Bypass bit selects raw/user framing, else automatic.
// R03 - Host sets variant before entering bypass mode.
// R04 - RF bit enables transmitter and receivers.
// R05 - Half power bit selects higher output impedance.
// R06 - Input choice bit selects auxiliary receive input.
// R07 - Gain bit enables automatic gain control.
// R08 - Forced bit keeps receiver and oscillator on.
// R09 - Supply bit selects 5 V or 3 V.
// R10 - Enable low or power-up presets 0x01, 0x02.
// R11 - Check-absent bit disables received CRC checking.
// R12 - Variant bit picks bypass mode 0 or 1.
// R13 - Peer bit selects reader or NFC/emulation.
// R14 - Reader: five-bit code; NFC: target or initiator.
// R15 - NFC bit three picks passive or active.
// R16 - NFC bit two picks normal or emulation.
// R17 - Low bits pick NFC rate or emulation type.
// R18 - Reader codes decode into vicinity, proximity, other.
// R19 - Protocol write reloads option registers 0x02-0x0B.
// R20 - Reads return stored value; writes act immediately.

module rfid_nfc_main_config_regs
  import rfid_cfg_pkg::*;
#(
  parameter int ADDR_W = `CFG_ADDR_W
)
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              device_activate_pin,
  input  wire logic              host_wr_en,
  input  wire logic              host_rd_en,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [7:0]        host_wdata,
  output logic      [7:0]        host_rdata,
  output logic                   host_rd_valid,
  output power_ctrl_t            power_ctrl,
  output protocol_reg_t          protocol_cfg,
  output protocol_info_t         protocol_info,
  output logic                   transmitter_enable,
  output logic                   receiver_enable,
  output logic                   tx_oscillator_enable,
  output logic                   crc_check_enable,
  output logic                   option_reload_valid,
  output logic      [ADDR_W-1:0] option_reload_addr,
  output protocol_reg_t          option_reload_protocol
);

  // ****************************************************************************
  // Register state
  // ****************************************************************************
  power_ctrl_t    ctrl_q,      ctrl_d;
  protocol_reg_t  proto_q,     proto_d;
  protocol_info_t info_q,      info_d;
  logic [7:0]     rdata_q,     rdata_d;
  logic           rvalid_q,    rvalid_d;
  logic           tx_en_q,     tx_en_d;
  logic           rx_en_q,     rx_en_d;
  logic           osc_en_q,    osc_en_d;
  logic           preset;
  logic           wr_ctrl;
  logic           wr_proto;

  function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] addr, input power_ctrl_t c,
                                          input protocol_reg_t p);
    logic [7:0] val;
    val = `CFG_UNMAPPED_READ;
    if (addr == ADDR_W'(`CFG_ADDR_CTRL)) begin
      val = c;
    end else if (addr == ADDR_W'(`CFG_ADDR_PROTO)) begin
      val = p;
    end
    return val;
  endfunction : reg_read

  assign preset   = reset || !device_activate_pin;  // see R10
  assign wr_ctrl  = host_wr_en && !preset && host_addr == ADDR_W'(`CFG_ADDR_CTRL);
  assign wr_proto = host_wr_en && !preset && host_addr == ADDR_W'(`CFG_ADDR_PROTO);

  always_comb begin
    ctrl_d   = ctrl_q;
    proto_d  = proto_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    if (preset) begin
      ctrl_d  = power_ctrl_t'(`CFG_CTRL_RESET);    // see R10
      proto_d = protocol_reg_t'(`CFG_PROTO_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_d = power_ctrl_t'(host_wdata);  // see R20
      end
      if (wr_proto) begin
        proto_d = protocol_reg_t'(host_wdata);
      end
    end
    if (host_rd_en) begin
      rvalid_d = 1'b1;
      rdata_d  = reg_read(host_addr, ctrl_q, proto_q);  // see R20
    end
    // Derived enables follow the new register value on the same edge.
    tx_en_d  = ctrl_d.rf_output_active;                                   // see R04
    rx_en_d  = ctrl_d.rf_output_active || ctrl_d.forced_receiver_enable;  // see R08
    osc_en_d = ctrl_d.rf_output_active || ctrl_d.forced_receiver_enable;
  end

  // Decoding the next value keeps the decoded mode aligned with the register.
  protocol_decode u_decode (
    .proto (proto_d),
    .info  (info_d)
  );

  always_ff @(posedge clk) begin
    ctrl_q   <= ctrl_d;
    proto_q  <= proto_d;
    info_q   <= info_d;
    rdata_q  <= rdata_d;
    rvalid_q <= rvalid_d;
    tx_en_q  <= tx_en_d;
    rx_en_q  <= rx_en_d;
    osc_en_q <= osc_en_d;
  end

  // ****************************************************************************
  // Option register reload sequencer
  // ****************************************************************************
  reload_state_t     state_q,  state_d;
  logic [ADDR_W-1:0] idx_q,    idx_d;
  protocol_reg_t     rl_pr_q,  rl_pr_d;

  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    rl_pr_d = rl_pr_q;
    if (preset) begin
      state_d = RELOAD_IDLE;
      idx_d   = ADDR_W'(`CFG_OPT_FIRST);
      rl_pr_d = protocol_reg_t'(`CFG_PROTO_RESET);
    end else if (wr_proto) begin
      // A new protocol write restarts the walk from the first option register.
      state_d = RELOAD_RUN;  // see R19
      idx_d   = ADDR_W'(`CFG_OPT_FIRST);
      rl_pr_d = protocol_reg_t'(host_wdata);
    end else begin
      case (state_q)
        RELOAD_IDLE: begin
          idx_d = ADDR_W'(`CFG_OPT_FIRST);
        end
        RELOAD_RUN: begin
          if (idx_q == ADDR_W'(`CFG_OPT_LAST)) begin
            state_d = RELOAD_IDLE;
          end else begin
            idx_d = idx_q + ADDR_W'(1);
          end
        end
        default: begin
          state_d = RELOAD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    state_q <= state_d;
    idx_q   <= idx_d;
    rl_pr_q <= rl_pr_d;
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************
  assign host_rdata             = rdata_q;
  assign host_rd_valid          = rvalid_q;
  assign power_ctrl             = ctrl_q;  // see R01 R02 R05 R06 R07 R09
  assign protocol_cfg           = proto_q;  // see R12
  assign protocol_info          = info_q;
  assign transmitter_enable     = tx_en_q;
  assign receiver_enable        = rx_en_q;
  assign tx_oscillator_enable   = osc_en_q;
  assign crc_check_enable       = !proto_q.receive_check_absent;  // see R11
  assign option_reload_valid    = (state_q == RELOAD_RUN);
  assign option_reload_addr     = idx_q;
  assign option_reload_protocol = rl_pr_q;

  // ****************************************************************************
  // Checks
  // ****************************************************************************
  // Strobe checks look one edge after the strobe, when the registered outputs
  // have taken the new value; chk_tx_off and chk_forced_receiver look in the same cycle.
  chk_preset_values: assert property (@(posedge clk)  // see R10
    preset |=> ctrl_q == power_ctrl_t'(`CFG_CTRL_RESET) && proto_q == protocol_reg_t'(`CFG_PROTO_RESET)
      && !option_reload_valid)
    else $error("Preset did not load the default register values.");

  chk_preset_enables: assert property (@(posedge clk)  // see R10
    preset |=> !transmitter_enable && !receiver_enable && !tx_oscillator_enable && crc_check_enable
      && option_reload_addr == ADDR_W'(`CFG_OPT_FIRST))
    else $error("Preset did not load the default enables.");

  chk_standby_write: assert property (@(posedge clk) disable iff (reset)  // see R01 R02
    wr_ctrl |=> power_ctrl.low_power_hold == $past(host_wdata[7])
      && power_ctrl.framing_bypass_select == $past(host_wdata[6]))
    else $error("Standby or bypass bit did not follow the write.");

  chk_power_fields: assert property (@(posedge clk) disable iff (reset)  // see R05 R06 R07 R09
    wr_ctrl |=> {power_ctrl.transmit_power_half, power_ctrl.receive_input_choice,
      power_ctrl.auto_gain_enable, power_ctrl.supply_range_select}
      == {$past(host_wdata[4]), $past(host_wdata[3]), $past(host_wdata[2]), $past(host_wdata[0])})
    else $error("Power, input, gain or supply bit did not follow the write.");

  chk_rf_enables: assert property (@(posedge clk) disable iff (reset)  // see R04
    wr_ctrl |=> transmitter_enable == $past(host_wdata[5])
      && receiver_enable == ($past(host_wdata[5]) || $past(host_wdata[1])))
    else $error("Transmitter or receiver enable wrong after a write.");

  chk_tx_off: assert property (@(posedge clk) disable iff (reset)  // see R04
    !power_ctrl.rf_output_active |-> !transmitter_enable)
    else $error("Transmitter on while the RF bit is clear.");

  chk_forced_receiver: assert property (@(posedge clk) disable iff (reset)  // see R08
    power_ctrl.forced_receiver_enable |-> receiver_enable && tx_oscillator_enable)
    else $error("Forced receiver bit did not hold receiver on.");

  chk_crc_select: assert property (@(posedge clk) disable iff (reset)  // see R11
    wr_proto |=> crc_check_enable == !$past(host_wdata[7]))
    else $error("Receive CRC checking does not follow the written bit.");

  chk_variant_bit: assert property (@(posedge clk) disable iff (reset)  // see R12 R13
    wr_proto |=> protocol_cfg.bypass_variant_select == $past(host_wdata[6])
      && protocol_cfg.reader_vs_peer_select == $past(host_wdata[5]))
    else $error("Variant or peer bit did not follow the write.");

  chk_reader_decode: assert property (@(posedge clk) disable iff (reset)  // see R18
    wr_proto && host_wdata[5:3] == 3'h1
      |=> protocol_info.family == ($past(host_wdata[2]) ? FAM_PROX_B : FAM_PROX_A))
    else $error("Proximity code decoded to the wrong family.");

  chk_reader_valid: assert property (@(posedge clk) disable iff (reset)  // see R14 R18
    wr_proto && !host_wdata[5] |=> protocol_info.code_valid == (!$past(host_wdata[4])
      || $past(host_wdata[4:0]) == `CFG_CODE_RATE2_A || $past(host_wdata[4:0]) == `CFG_CODE_RATE2_B))
    else $error("Reader protocol code validity decoded wrongly.");

  chk_nfc_roles: assert property (@(posedge clk) disable iff (reset)  // see R14 R15
    wr_proto && host_wdata[5] |=> protocol_info.nfc_initiator == $past(host_wdata[4])
      && protocol_info.nfc_active == $past(host_wdata[3]))
    else $error("NFC role or communication mode decoded wrongly.");

  chk_nfc_rate: assert property (@(posedge clk) disable iff (reset)  // see R16 R17
    wr_proto && host_wdata[5] && !host_wdata[2]
      |=> protocol_info.family == FAM_NFC_NORMAL && protocol_info.rate_sel == $past(host_wdata[1:0]))
    else $error("NFC normal mode or bit rate decoded wrongly.");

  chk_nfc_emulation: assert property (@(posedge clk) disable iff (reset)  // see R16 R17
    wr_proto && host_wdata[5] && host_wdata[2] && !host_wdata[1]
      |=> protocol_info.family == ($past(host_wdata[0]) ? FAM_CARD_EMU_B : FAM_CARD_EMU_A))
    else $error("Card emulation type decoded wrongly.");

  chk_reload_start: assert property (@(posedge clk) disable iff (reset)  // see R19
    wr_proto |=> option_reload_valid && option_reload_addr == ADDR_W'(`CFG_OPT_FIRST)
      && option_reload_protocol == protocol_reg_t'($past(host_wdata)))
    else $error("Protocol write did not start the option reload.");

  chk_reload_step: assert property (@(posedge clk) disable iff (preset)  // see R19
    option_reload_valid && option_reload_addr != ADDR_W'(`CFG_OPT_LAST) && !wr_proto
      |=> option_reload_valid && option_reload_addr == $past(option_reload_addr) + ADDR_W'(1))
    else $error("Option reload skipped or stopped before the last register.");

  chk_reload_span: assert property (@(posedge clk) disable iff (preset)  // see R19
    option_reload_valid && option_reload_addr == ADDR_W'(`CFG_OPT_LAST) && !wr_proto |=> !option_reload_valid)
    else $error("Option reload did not end at the last option register.");

  chk_read_back: assert property (@(posedge clk) disable iff (reset)  // see R20
    host_rd_en && host_addr == ADDR_W'(`CFG_ADDR_PROTO) |=> host_rd_valid && host_rdata == $past(proto_q))
    else $error("Read of the protocol register returned a wrong value.");

  chk_read_ctrl: assert property (@(posedge clk) disable iff (reset)  // see R20
    host_rd_en && host_addr == ADDR_W'(`CFG_ADDR_CTRL) |=> host_rd_valid && host_rdata == $past(power_ctrl))
    else $error("Read of the power register returned a wrong value.");

  chk_read_unmapped: assert property (@(posedge clk) disable iff (reset)  // see R20
    host_rd_en && host_addr != ADDR_W'(`CFG_ADDR_CTRL) && host_addr != ADDR_W'(`CFG_ADDR_PROTO)
      |=> host_rd_valid && host_rdata == `CFG_UNMAPPED_READ)
    else $error("Read of an unmapped address returned a wrong value.");

  chk_valid_pulse: assert property (@(posedge clk) disable iff (reset)  // see R20
    !host_rd_en |=> !host_rd_valid)
    else $error("Read valid shown without a read strobe.");

  chk_hold_ctrl: assert property (@(posedge clk) disable iff (reset)  // see R20
    !preset && !wr_ctrl |=> $stable(power_ctrl))
    else $error("Power register changed without a write.");

  chk_hold_proto: assert property (@(posedge clk) disable iff (reset)  // see R20
    !preset && !wr_proto |=> $stable(protocol_cfg))
    else $error("Protocol register changed without a write.");

endmodule : rfid_nfc_main_config_regs

// file: dv/host_port_model.sv
`timescale 1ns/10ps

module host_port_model #(
  parameter int ADDR_W = 5
)
(
  input  wire logic              clk,
  output logic                   host_wr_en,
  output logic                   host_rd_en,
  output logic      [ADDR_W-1:0] host_addr,
  output logic      [7:0]        host_wdata,
  input  wire logic [7:0]        host_rdata,
  input  wire logic              host_rd_valid
);

  initial begin
    host_wr_en = 1'b0;
    host_rd_en = 1'b0;
    host_addr  = '0;
    host_wdata = 8'h00;
  end

  // ****************************************************************************
  // One strobed cycle; released address and data lines show the inverse so stale values never pass.
  // ****************************************************************************
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    host_wr_en = wr;
    host_rd_en = !wr;
    host_addr  = addr;
    host_wdata = data;
    @(posedge clk);
    #1;
    host_wr_en = 1'b0;
    host_rd_en = 1'b0;
    host_addr  = ~host_addr;
    host_wdata = ~host_wdata;
  endtask : issue

  task automatic rd(input logic [ADDR_W-1:0] addr, output logic [7:0] data, output logic ok);
    int n;
    issue(1'b0, addr, 8'h00);
    for (n = 0; n < 4 && host_rd_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    ok   = (host_rd_valid === 1'b1);
    data = host_rdata;
  endtask : rd

endmodule : host_port_model

// file: dv/testbench.sv
`timescale 1ns/10ps
`include "rfid_cfg_params.svh"

module testbench
  import rfid_cfg_pkg::*;
;
  logic           clk;
  logic           reset;
  logic           device_activate_pin;
  logic           host_wr_en;
  logic           host_rd_en;
  logic [4:0]     host_addr;
  logic [7:0]     host_wdata;
  logic [7:0]     host_rdata;
  logic           host_rd_valid;
  power_ctrl_t    power_ctrl;
  protocol_reg_t  protocol_cfg;
  protocol_info_t protocol_info;
  logic           transmitter_enable;
  logic           receiver_enable;
  logic           tx_oscillator_enable;
  logic           crc_check_enable;
  logic           option_reload_valid;
  logic [4:0]     option_reload_addr;
  protocol_reg_t  option_reload_protocol;
  int             err_count = 0;
  int             tests_run = 0;
  int             ctrl_m;
  int             proto_m;

  rfid_nfc_main_config_regs u_dut (.clk(clk), .reset(reset), .device_activate_pin(device_activate_pin),
    .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rd_valid(host_rd_valid), .power_ctrl(power_ctrl),
    .protocol_cfg(protocol_cfg), .protocol_info(protocol_info), .transmitter_enable(transmitter_enable),
    .receiver_enable(receiver_enable), .tx_oscillator_enable(tx_oscillator_enable),
    .crc_check_enable(crc_check_enable), .option_reload_valid(option_reload_valid),
    .option_reload_addr(option_reload_addr), .option_reload_protocol(option_reload_protocol));

  host_port_model u_host (.clk(clk), .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rd_valid(host_rd_valid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************************
  // Reference model and comparison helpers
  // ****************************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic protocol_family_t exp_family(input int p);
    int code;
    code = p & 31;
    if ((p & 32) == 0) begin
      if (code < 8) return FAM_VICINITY;
      if (code < 12) return FAM_PROX_A;
      if (code < 16) return FAM_PROX_B;
      if (code == 26 || code == 27) return FAM_RATE2;
      return FAM_RESERVED;
    end
    if ((p & 4) == 0) return FAM_NFC_NORMAL;
    if ((p & 3) == 0) return FAM_CARD_EMU_A;
    if ((p & 3) == 1) return FAM_CARD_EMU_B;
    return FAM_RESERVED;
  endfunction : exp_family

  task automatic check_all();
    protocol_family_t fam;
    logic [7:0]       rdat;
    logic             ok;
    fam = exp_family(proto_m);
    check(power_ctrl, ctrl_m[7:0]);
    check(protocol_cfg, proto_m[7:0]);
    check({7'h00, transmitter_enable}, {7'h00, ctrl_m[5]});
    check({6'h00, receiver_enable, tx_oscillator_enable}, {6'h00, {2{ctrl_m[5] | ctrl_m[1]}}});
    check({7'h00, crc_check_enable}, {7'h00, !proto_m[7]});
    check({5'h00, protocol_info.family}, {5'h00, fam});
    check({7'h00, protocol_info.code_valid}, {7'h00, fam != FAM_RESERVED &&
          !(fam == FAM_NFC_NORMAL && (proto_m & 3) == 0)});
    check({6'h00, protocol_info.rate_sel}, {6'h00, proto_m[1:0]});
    if (proto_m[5]) begin
      check({6'h00, protocol_info.nfc_initiator, protocol_info.nfc_active}, {6'h00, proto_m[4:3]});
    end
    u_host.rd(`CFG_ADDR_CTRL, rdat, ok);
    check({ok, rdat[6:0]}, {1'b1, ctrl_m[6:0]});
    check(rdat, ctrl_m[7:0]);
    u_host.rd(`CFG_ADDR_PROTO, rdat, ok);
    check({7'h00, ok}, 8'h01);
    check(rdat, proto_m[7:0]);
  endtask : check_all

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.issue(1'b1, a, d);
    if (a == `CFG_ADDR_CTRL) ctrl_m = d;
    if (a == `CFG_ADDR_PROTO) proto_m = d;
  endtask : wr

  task automatic check_walk(input int start, input int steps);
    int i;
    for (i = start; i < start + steps; i++) begin
      check({option_reload_valid, 2'h0, option_reload_addr}, {1'b1, 2'h0, 5'(i)});
      check(option_reload_protocol, proto_m[7:0]);
      @(posedge clk);
      #1;
    end
  endtask : check_walk

  task automatic print_verdict();
    $display("Counts: tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    #400us;
    err_count++;
    print_verdict();
  end

  // ****************************************************************************
  // Main sequence
  // ****************************************************************************
  initial begin
    logic [7:0] rdat;
    logic       ok;
    int         i;
    void'($urandom(32'hf82043ae));
    reset = 1'b1;
    device_activate_pin = 1'b1;
    ctrl_m = 8'h01;
    proto_m = 8'h02;
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    check_all();
    check({7'h00, option_reload_valid}, 8'h00);
    $display("test reset values done");
    for (i = 0; i < 8; i++) begin
      wr(`CFG_ADDR_CTRL, 8'(1 << i));
      check_all();
    end
    for (i = 0; i < 20; i++) begin
      wr(`CFG_ADDR_CTRL, 8'($urandom));
      check_all();
    end
    $display("test control register done");
    for (i = 0; i < 256; i++) begin
      wr(`CFG_ADDR_PROTO, 8'(i));
      check_all();
    end
    $display("test protocol decode done");
    wr(`CFG_ADDR_PROTO, 8'h0D);
    check_walk(2, 4);
    wr(`CFG_ADDR_PROTO, 8'h4D);
    check_walk(2, 10);
    check({option_reload_valid, 7'h00}, 8'h00);
    wr(`CFG_ADDR_CTRL, 8'h41);
    check_all();
    $display("test reload walk done");
    wr(`CFG_ADDR_PROTO, 8'h0C);
    device_activate_pin = 1'b0;
    u_host.issue(1'b1, `CFG_ADDR_CTRL, 8'hFF);
    ctrl_m = 8'h01;
    proto_m = 8'h02;
    check({option_reload_valid, 7'h00}, 8'h00);
    device_activate_pin = 1'b1;
    check_all();
    wr(`CFG_ADDR_CTRL, 8'h24);
    reset = 1'b1;
    @(posedge clk);
    #1;
    reset = 1'b0;
    ctrl_m = 8'h01;
    check_all();
    u_host.rd(5'h1F, rdat, ok);
    check({ok, 7'h00}, 8'h80);
    check(rdat, `CFG_UNMAPPED_READ);
    $display("test preset and unmapped done");
    print_verdict();
  end

endmodule : testbench
